/* rta_core.sv */
// Timer, alarm comparator, capture path and oscillator control of the RTC
`timescale 1ns/1ps

// How it works
// - 47-bit timer counts up once per RTC tick while timer_run is 1.
// - Load and snapshot work while the timer keeps running.
// - Load value is capture bytes with bit 0 of byte 0 dropped.
// - Writing 1 to timer_load_request copies capture bytes into the timer.
// - timer_load_request clears itself once the load has happened.
// - timer_snapshot_request=1 copies timer into capture, timer LSB at bit 1.
// - timer_snapshot_request clears itself when the snapshot is stored.
// - Full 47-bit timer compared continuously against the alarm target.
// - Alarm fires when timer is greater than or equal to target.
// - Alarm with interrupt enabled requests the RTC interrupt.
// - Alarm with reset source enabled requests a whole-chip reset.
// - Alarm always wakes the internal oscillator from suspend.
module rta_core
  import rta_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       rtc_tick,
  input  wire rta_cpu_s   cpu,
  input  wire logic       irq_enable,
  input  wire logic       reset_source_enable,
  input  wire logic       osc_clock_valid,
  input  wire logic       backup_battery_enable,
  output logic [7:0]      indirect_address_port,
  output logic [7:0]      indirect_data_port,
  output logic            rtc_irq,
  output logic            mcu_reset_req,
  output logic            osc_wake,
  output logic            auto_gain_enable,
  output logic            crystal_select,
  output logic            bias_double,
  output logic            rtc_enable
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]         timer_capture_bytes [NBYTES];
  logic [7:0]         alarm_target_bytes  [NBYTES];
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] alarm_target;
  logic [TIMER_W-1:0] load_value;
  logic [8*NBYTES-1:0] cap_flat;
  logic [8*NBYTES-1:0] next_cap_flat;
  logic               timer_run;
  logic               alarm_event_enable;
  logic               alarm_flag;
  logic               timer_load_request;
  logic               timer_snapshot_request;
  logic               alarm_hit;
  logic               data_wr;
  rta_xfer_e          xfer;

  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [3:0] target);
    is_addr = (a[3:0] == target) && (a[6:4] == 3'h0);
  endfunction

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (a[6:4] == 3'h0) && (a[3:0] >= lo) && (a[3:0] <= hi);
  endfunction

  assign data_wr = cpu.dat_wr;

  // ---------------------------------------------------------------
  // Indirect address register
  // ---------------------------------------------------------------
  // Accesses finish in one cycle, so the busy bit always reads 0
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      indirect_address_port <= BYTE_ZERO;
    end else if (cpu.adr_wr) begin
      indirect_address_port <= {1'b0, cpu.wdata[6:0]};
    end
  end

  // ---------------------------------------------------------------
  // Byte views of the 47-bit quantities
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_flat
      assign cap_flat[8*gi +: 8] = timer_capture_bytes[gi];
      assign alarm_target[(8*gi) +: ((gi == NBYTES-1) ? 7 : 8)] =
        alarm_target_bytes[gi][((gi == NBYTES-1) ? 7 : 8)-1:0];
    end
  endgenerate

  // set value skips capture bit 0
  assign load_value    = cap_flat[TIMER_W:1];
  // timer LSB lands on capture bit 1
  assign next_cap_flat = {timer, 1'b0};

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  // load first, snapshot on a later tick
  always_comb begin
    xfer = XFER_IDLE;
    if (rtc_tick) begin
      if (timer_load_request) begin
        xfer = XFER_LOAD;
      end else if (timer_snapshot_request) begin
        xfer = XFER_SNAP;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer <= '0;
    end else begin
      case (xfer)
        XFER_LOAD: begin
          timer <= load_value;
        end
        default: begin
          if (rtc_tick && timer_run) begin
            timer <= timer + 1'b1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Capture and alarm bytes
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_bytes
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          timer_capture_bytes[gi] <= CAPTURE_RESET;
        end else if (xfer == XFER_SNAP) begin
          timer_capture_bytes[gi] <= next_cap_flat[8*gi +: 8];
        end else if (data_wr &&
                     is_addr(indirect_address_port,
                             ADR_CAPTURE0 + 4'(gi))) begin
          timer_capture_bytes[gi] <= cpu.wdata;
        end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          alarm_target_bytes[gi] <= ALARM_RESET;
        end else if (data_wr &&
                     is_addr(indirect_address_port,
                             ADR_ALARM0 + 4'(gi))) begin
          alarm_target_bytes[gi] <= cpu.wdata;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rtc_enable         <= 1'b0;
      timer_run          <= 1'b0;
      alarm_event_enable <= 1'b0;
    end else if (data_wr && is_addr(indirect_address_port, ADR_CONTROL)) begin
      rtc_enable         <= cpu.wdata[CTL_ENABLE_BIT];
      timer_run          <= cpu.wdata[CTL_RUN_BIT];
      alarm_event_enable <= cpu.wdata[CTL_AEN_BIT];
    end
  end

  // Writing 0 to a request bit never cancels a pending transfer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_load_request <= 1'b0;
    end else if (data_wr && is_addr(indirect_address_port, ADR_CONTROL) &&
                 cpu.wdata[CTL_LOAD_BIT]) begin
      timer_load_request <= 1'b1;
    end else if (xfer == XFER_LOAD) begin
      timer_load_request <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_snapshot_request <= 1'b0;
    end else if (data_wr && is_addr(indirect_address_port, ADR_CONTROL) &&
                 cpu.wdata[CTL_SNAP_BIT]) begin
      timer_snapshot_request <= 1'b1;
    end else if (xfer == XFER_SNAP) begin
      timer_snapshot_request <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Alarm
  // ---------------------------------------------------------------
  // full-width compare
  // greater or equal, not only equal
  assign alarm_hit = alarm_event_enable && (timer >= alarm_target);

  // Set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm_flag <= 1'b0;
    end else if (alarm_hit) begin
      alarm_flag <= 1'b1;
    end else if (data_wr && is_addr(indirect_address_port, ADR_CONTROL) &&
                 !cpu.wdata[CTL_ALARM_BIT]) begin
      alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rtc_irq       <= 1'b0;
      mcu_reset_req <= 1'b0;
      osc_wake      <= 1'b0;
    end else begin
      rtc_irq       <= irq_enable && (alarm_flag || alarm_hit);
      mcu_reset_req <= reset_source_enable && alarm_hit;
      osc_wake      <= alarm_hit;
    end
  end

  // ---------------------------------------------------------------
  // Oscillator control
  // ---------------------------------------------------------------
  // writable oscillator settings
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      auto_gain_enable <= 1'b0;
      crystal_select   <= 1'b0;
      bias_double      <= 1'b0;
    end else if (data_wr &&
                 is_addr(indirect_address_port, ADR_OSC_CTRL)) begin
      auto_gain_enable <= cpu.wdata[OSC_AGC_BIT];
      crystal_select   <= cpu.wdata[OSC_XSEL_BIT];
      bias_double      <= cpu.wdata[OSC_BIAS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Read data, one cycle behind the address
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      indirect_data_port <= BYTE_ZERO;
    end else begin
      indirect_data_port <= BYTE_ZERO;
      if (in_range(indirect_address_port, ADR_CAPTURE0, ADR_CAPTURE5)) begin
        indirect_data_port <=
          timer_capture_bytes[indirect_address_port[2:0]];
      end else if (in_range(indirect_address_port,
                            ADR_ALARM0, ADR_ALARM5)) begin
        indirect_data_port <=
          alarm_target_bytes[3'(indirect_address_port[3:0] - ADR_ALARM0)];
      end else if (is_addr(indirect_address_port, ADR_CONTROL)) begin
        indirect_data_port[CTL_ENABLE_BIT] <= rtc_enable;
        indirect_data_port[CTL_RUN_BIT]    <= timer_run;
        indirect_data_port[CTL_AEN_BIT]    <= alarm_event_enable;
        indirect_data_port[CTL_ALARM_BIT]  <= alarm_flag;
        indirect_data_port[CTL_LOAD_BIT]   <= timer_load_request;
        indirect_data_port[CTL_SNAP_BIT]   <= timer_snapshot_request;
      end else if (is_addr(indirect_address_port, ADR_OSC_CTRL)) begin
        // valid and battery bits are read-only
        indirect_data_port[OSC_AGC_BIT]   <= auto_gain_enable;
        indirect_data_port[OSC_XSEL_BIT]  <= crystal_select;
        indirect_data_port[OSC_BIAS_BIT]  <= bias_double;
        indirect_data_port[OSC_VALID_BIT] <= osc_clock_valid;
        indirect_data_port[OSC_VBAT_BIT]  <= backup_battery_enable;
      end
    end
  end

endmodule

/* rta_pkg.sv */
// Constants and types for the real-time-clock timer, alarm and capture core
package rta_pkg;

  // ---------------------------------------------------------------
  // Indirect register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_CAPTURE0   = 4'h0;
  localparam logic [3:0] ADR_CAPTURE5   = 4'h5;
  localparam logic [3:0] ADR_CONTROL    = 4'h6;
  localparam logic [3:0] ADR_OSC_CTRL   = 4'h7;
  localparam logic [3:0] ADR_ALARM0     = 4'h8;
  localparam logic [3:0] ADR_ALARM5     = 4'hD;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_ENABLE_BIT   = 7;
  localparam int CTL_RUN_BIT      = 4;
  localparam int CTL_AEN_BIT      = 3;
  localparam int CTL_ALARM_BIT    = 2;
  localparam int CTL_LOAD_BIT     = 1;
  localparam int CTL_SNAP_BIT     = 0;
  localparam int OSC_AGC_BIT      = 7;
  localparam int OSC_XSEL_BIT     = 6;
  localparam int OSC_BIAS_BIT     = 5;
  localparam int OSC_VALID_BIT    = 4;
  localparam int OSC_VBAT_BIT     = 0;
  localparam int ADR_BUSY_BIT     = 7;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int TIMER_W = 47;
  localparam int NBYTES  = 6;
  localparam logic [7:0] CAPTURE_RESET = 8'hFF;
  localparam logic [7:0] ALARM_RESET   = 8'hFF;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       adr_wr;
    logic       dat_wr;
    logic [7:0] wdata;
  } rta_cpu_s;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_LOAD,
    XFER_SNAP
  } rta_xfer_e;

endpackage

/* rta_core_sva.sv */
// Port assertions for the RTC timer, alarm and capture core
`timescale 1ns/1ps
module rta_core_sva
  import rta_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       rtc_tick,
  input wire rta_cpu_s   cpu,
  input wire logic       irq_enable,
  input wire logic       reset_source_enable,
  input wire logic [7:0] indirect_address_port,
  input wire logic [7:0] indirect_data_port,
  input wire logic       rtc_irq,
  input wire logic       mcu_reset_req,
  input wire logic       osc_wake,
  input wire logic       auto_gain_enable,
  input wire logic       crystal_select,
  input wire logic       bias_double
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ctl_sel;
  assign ctl_sel = indirect_address_port[6:0] == 7'h06;
  wake_irq_a: assert property
    (osc_wake && $past(irq_enable) |-> rtc_irq)
    else $error("alarm wake without interrupt");
  irq_gate_a: assert property (!$past(irq_enable) |-> !rtc_irq)
    else $error("interrupt while disabled");
  reset_req_a: assert property (mcu_reset_req ==
    (osc_wake && $past(reset_source_enable))) else $error("reset request");
  osc_read_a: assert property (indirect_address_port[6:0] == 7'h07 |=>
    indirect_data_port[7:5] ==
    $past({auto_gain_enable, crystal_select, bias_double}))
    else $error("osc control readback");
  osc_write_a: assert property
    ($changed({auto_gain_enable, crystal_select, bias_double}) |->
    $past(cpu.dat_wr) && $past(indirect_address_port[6:0]) == 7'h07)
    else $error("osc control changed unasked");
  unmapped_zero_a: assert property (indirect_address_port[6:4] != 3'h0
    |=> indirect_data_port == 8'h00) else $error("unmapped read");
  load_done_a: assert property ($past(ctl_sel) && $past(ctl_sel, 2) &&
    $fell(indirect_data_port[1]) |-> $past(rtc_tick, 2))
    else $error("load cleared off tick");
  snap_done_a: assert property ($past(ctl_sel) && $past(ctl_sel, 2) &&
    $fell(indirect_data_port[0]) |-> $past(rtc_tick, 2))
    else $error("snapshot cleared off tick");
  cover property (osc_wake && rtc_irq);
  cover property (mcu_reset_req);
  cover property (ctl_sel && $fell(indirect_data_port[0]));
endmodule

/* rta_core_tb_top.sv */
// Self-checking bench for the RTC timer, alarm and capture core
`timescale 1ns/1ps
module rta_core_tb_top;
  import rta_pkg::*;
  logic        sys_clk, rst, rtc_tick, irq_enable, reset_source_enable;
  logic        osc_clock_valid, backup_battery_enable, rtc_irq;
  logic        mcu_reset_req, osc_wake, auto_gain_enable, crystal_select;
  logic        bias_double, rtc_enable;
  rta_cpu_s    cpu;
  logic [7:0]  indirect_address_port, indirect_data_port, rd_v;
  logic [47:0] cap;
  int          n_fail, n_checks, k;

  rta_core dut (.sys_clk, .rst, .rtc_tick, .cpu, .irq_enable,
    .reset_source_enable, .osc_clock_valid, .backup_battery_enable,
    .indirect_address_port, .indirect_data_port, .rtc_irq, .mcu_reset_req,
    .osc_wake, .auto_gain_enable, .crystal_select, .bias_double,
    .rtc_enable);

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wadr(input logic [7:0] a);
    cpu.adr_wr = 1'b1;
    cpu.wdata  = a;
    step;
    cpu.adr_wr = 1'b0;
    step;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wadr(a);
    cpu.dat_wr = 1'b1;
    cpu.wdata  = d;
    step;
    cpu.dat_wr = 1'b0;
    step;
  endtask
  // Data port lags the address by one edge, settled when wadr returns
  task automatic rd(input logic [7:0] a);
    wadr(a);
    rd_v = indirect_data_port;
  endtask
  task automatic tick;
    rtc_tick = 1'b1;
    step;
    rtc_tick = 1'b0;
    step;
  endtask
  task automatic wbytes(input logic [7:0] base, input logic [47:0] v);
    for (int i = 0; i < NBYTES; i++) begin
      wreg(base + 8'(i), v[8*i +: 8]);
    end
  endtask
  task automatic rcap;
    for (int i = 0; i < NBYTES; i++) begin
      rd(8'(i));
      cap[8*i +: 8] = rd_v;
    end
  endtask
  task automatic snap(input logic [46:0] exp);
    wreg(8'h06, 8'h91);
    rd(8'h06);
    chk(rd_v[0], 1'b1);
    tick;
    rd(8'h06);
    chk(rd_v[0], 1'b0);
    rcap;
    chk(cap, {exp, 1'b0});
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #(50 * 20000);
    n_fail++;
    give_verdict;
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cpu = '0;
    {rtc_tick, irq_enable, reset_source_enable} = 3'h0;
    {osc_clock_valid, backup_battery_enable} = 2'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < NBYTES; i++) begin
      rd(8'(i));
      chk(rd_v, CAPTURE_RESET);
      rd(8'(i + 8));
      chk(rd_v, ALARM_RESET);
    end
    // Busy bit of the address register never sticks
    rd(8'h90);
    chk(rd_v, 8'h00);
    chk({rtc_enable, indirect_address_port}, 9'h010);
    {osc_clock_valid, backup_battery_enable, irq_enable} = 3'h7;
    wreg(8'h07, 8'hE0);
    rd(8'h07);
    chk(rd_v & 8'hF1, 8'hF1);
    chk({auto_gain_enable, crystal_select, bias_double}, 3'h7);
    {osc_clock_valid, backup_battery_enable} = 2'h0;
    wreg(8'h07, 8'h1F);
    rd(8'h07);
    chk(rd_v & 8'hF1, 8'h00);
    // Ticks while stopped must not count
    repeat (2) tick;
    wreg(8'h06, 8'h90);
    chk(rtc_enable, 1'b1);
    repeat (5) tick;
    snap(47'd5);
    wbytes(8'h00, 48'hF0E1_D2C3_B4A5);
    wreg(8'h06, 8'h92);
    rd(8'h06);
    chk(rd_v[1], 1'b1);
    tick;
    rd(8'h06);
    chk(rd_v[1], 1'b0);
    repeat (2) tick;
    snap(47'h7870_E961_DA54);
    // Both pending from the all-ones value, so the timer wraps
    wbytes(8'h00, 48'hFFFF_FFFF_FFFF);
    wreg(8'h06, 8'h93);
    tick;
    rd(8'h06);
    chk(rd_v[1:0], 2'b01);
    k = 1;
    while (rd_v[0] === 1'b1 && k < 5) begin
      tick;
      rd(8'h06);
      k++;
    end
    chk(rd_v[1:0], 2'b00);
    rcap;
    chk(cap, {47'h7FFF_FFFF_FFFF + 47'(k - 2), 1'b0});
    snap(47'(k - 2));
    wreg(8'h06, 8'h90);
    wbytes(8'h08, 48'(k + 1));
    wreg(8'h06, 8'h98);
    tick;
    chk(osc_wake, 1'b0);
    tick;
    step;
    chk({osc_wake, rtc_irq, mcu_reset_req}, 3'b110);
    reset_source_enable = 1'b1;
    tick;
    step;
    chk({osc_wake, rtc_irq, mcu_reset_req}, 3'b111);
    rd(8'h06);
    chk(rd_v[2], 1'b1);
    // Events off while the target is rewritten, flag kept
    wreg(8'h06, 8'h94);
    wbytes(8'h08, 48'h0200_0000_0000);
    wreg(8'h06, 8'h9C);
    step;
    chk({osc_wake, rtc_irq, mcu_reset_req}, 3'b010);
    wreg(8'h06, 8'h94);
    wbytes(8'h08, 48'hFFFF_FFFF_FFFF);
    wreg(8'h06, 8'h98);
    rd(8'h06);
    chk({rd_v[2], osc_wake, rtc_irq, mcu_reset_req}, 4'h0);
    give_verdict;
  end
endmodule

bind rta_core rta_core_sva u_sva (.sys_clk, .rst, .rtc_tick, .cpu,
  .irq_enable, .reset_source_enable, .indirect_address_port,
  .indirect_data_port, .rtc_irq, .mcu_reset_req, .osc_wake,
  .auto_gain_enable, .crystal_select, .bias_double);
